//--- src/btov_core.sv
// How it works
// - Toggle one indexed bit, write byte back
// - Toggle opcode is 0111 bbba ffff ffff
// - Bank flag 0 uses access bank
// - Bank flag 1 uses bank select
// - Toggle leaves status flags unchanged
// - Branch taken only when overflow set
// - Taken branch adds doubled signed offset
// - Target is address plus two plus 2n
// - One cycle untaken, two when taken
`timescale 1ns/10ps
`default_nettype none
module btov_core #(
  parameter int PC_W = btov_pkg::PC_W // Program counter width
) (
  // Clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // Instruction from fetch
  input  wire logic [15:0]           instr_i,
  input  wire logic                  instr_vld_i,
  // Core state
  input  wire logic                  ovf_flag_i,
  input  wire logic [3:0]            bank_select_reg_i,
  // Data memory port
  output btov_pkg::btov_dmem_t       dmem_o,
  input  wire logic [7:0]            dmem_rdata_i,
  // Program counter
  output logic [PC_W-1:0]            pc_o,
  output logic                       pc_load_o,
  // Phase and status
  output btov_pkg::btov_phase_t      phase_o,
  output logic                       flush_o,
  output logic                       flags_we_o
);
  // Offset doubling needs room above bit 8
  if (PC_W < 10) begin : g_pc_w_chk
    $error("PC_W too small");
  end

  // Decoded fields
  logic       is_inv;
  logic       is_br;
  logic [2:0] bit_idx;
  logic       bank_flag;
  logic [7:0] file_a;
  logic [7:0] offset;

  btov_decode u_dec (
    .instr_i     (instr_i),
    .is_invert_o (is_inv),
    .is_branch_o (is_br),
    .bit_idx_o   (bit_idx),
    .bank_flag_o (bank_flag),
    .file_o      (file_a),
    .offset_o    (offset)
  );

  // Phase, latched instruction, PC and pipeline state
  btov_pkg::btov_phase_t phase_r, phase_nxt;
  logic [PC_W-1:0]       pc_r, pc_nxt;
  logic                  inv_r, br_r, flush_r, flush_nxt;
  logic [2:0]            idx_r;
  logic [btov_pkg::ADDR_W-1:0] addr_r;
  logic [7:0]            off_r;
  logic [7:0]            data_r, data_nxt;
  logic                  take_r;
  logic                  pc_load_r;
  btov_pkg::btov_dmem_t  dmem_r, dmem_nxt;

  // Access bank split: low half to bank 0, high half to the top bank
  function automatic logic [btov_pkg::ADDR_W-1:0] data_addr(
    input logic a, input logic [3:0] bank_sel, input logic [7:0] f);
    logic [3:0] bank;
    bank = (f >= btov_pkg::ACCESS_SPLIT) ? btov_pkg::ACCESS_BANK_HI
                                         : btov_pkg::ACCESS_BANK_LO;
    if (a) begin
      bank = bank_sel;
    end
    return {bank, f};
  endfunction

  // Sign extended, doubled offset
  function automatic logic [PC_W-1:0] rel_off(input logic [7:0] n);
    return {{(PC_W-9){n[7]}}, n, 1'b0};
  endfunction

  wire [btov_pkg::ADDR_W-1:0] addr_w = data_addr(bank_flag, bank_select_reg_i, file_a);
  // pc_r already points past the branch word, so target is PC+2+2n
  wire [PC_W-1:0] br_target = pc_r + rel_off(off_r);
  wire [7:0]      toggled   = data_r ^ (8'h01 << idx_r);
  wire            new_instr = (phase_r == btov_pkg::BTOV_Q1) && instr_vld_i && !flush_r;

  // Next phase: simple ring Q1..Q4
  always_comb begin
    unique case (phase_r)
      btov_pkg::BTOV_Q1: phase_nxt = btov_pkg::BTOV_Q2;
      btov_pkg::BTOV_Q2: phase_nxt = btov_pkg::BTOV_Q3;
      btov_pkg::BTOV_Q3: phase_nxt = btov_pkg::BTOV_Q4;
      btov_pkg::BTOV_Q4: phase_nxt = btov_pkg::BTOV_Q1;
    endcase
  end

  // Next values of data path, memory port, PC
  always_comb begin
    dmem_nxt  = '0;
    data_nxt  = data_r;
    pc_nxt    = pc_r;
    flush_nxt = flush_r;
    unique case (phase_r)
      btov_pkg::BTOV_Q1: begin
        // Fetch of the next word advances the PC by one word
        if (!flush_r) begin
          pc_nxt = pc_r + PC_W'(2);
        end
        flush_nxt = 1'b0; // Refill cycle ends here
      end
      btov_pkg::BTOV_Q2: begin
        if (inv_r) begin
          dmem_nxt.rd   = 1'b1;
          dmem_nxt.addr = addr_r;
        end
      end
      btov_pkg::BTOV_Q3: begin
        if (inv_r) begin
          data_nxt = dmem_rdata_i;
        end
      end
      btov_pkg::BTOV_Q4: begin
        if (inv_r) begin
          dmem_nxt.wr    = 1'b1;
          dmem_nxt.addr  = addr_r;
          dmem_nxt.wdata = toggled;
        end
        if (br_r && take_r) begin
          pc_nxt    = br_target;
          flush_nxt = 1'b1;
        end
      end
    endcase
  end

  // Phase and pipeline registers
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      phase_r   <= btov_pkg::BTOV_Q1;
      pc_r      <= '0;
      flush_r   <= 1'b0;
      data_r    <= 8'h00;
      dmem_r    <= '0;
      pc_load_r <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      pc_r      <= pc_nxt;
      flush_r   <= flush_nxt;
      data_r    <= data_nxt;
      dmem_r    <= dmem_nxt;
      pc_load_r <= (phase_r == btov_pkg::BTOV_Q4) && br_r && take_r;
    end
  end

  // Instruction latch at Q1 decode; flushed cycle carries nothing
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      inv_r  <= 1'b0;
      br_r   <= 1'b0;
      take_r <= 1'b0;
      idx_r  <= 3'h0;
      addr_r <= '0;
      off_r  <= 8'h00;
    end else if (phase_r == btov_pkg::BTOV_Q1) begin
      inv_r  <= new_instr && is_inv;
      br_r   <= new_instr && is_br;
      take_r <= ovf_flag_i;
      idx_r  <= bit_idx;
      addr_r <= addr_w;
      off_r  <= offset;
    end
  end

  // Outputs
  assign dmem_o     = dmem_r;
  assign pc_o       = pc_r;
  assign pc_load_o  = pc_load_r;
  assign phase_o    = phase_r;
  assign flush_o    = flush_r;
  assign flags_we_o = 1'b0;

  // Assertions
  phase_ring_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    phase_r == btov_pkg::BTOV_Q1 |=> phase_r == btov_pkg::BTOV_Q2 ##1
    phase_r == btov_pkg::BTOV_Q3 ##1 phase_r == btov_pkg::BTOV_Q4)
    else $error("phase ring broken");
  toggle_write_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    phase_r == btov_pkg::BTOV_Q4 && inv_r |=>
    dmem_o.wr && dmem_o.wdata == ($past(data_r) ^ (8'h01 << $past(idx_r))))
    else $error("toggle write wrong");
  one_bit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dmem_o.wr |-> $countones(dmem_o.wdata ^ data_r) == 1)
    else $error("more than one bit changed");
  read_q2_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    dmem_o.rd |-> phase_r == btov_pkg::BTOV_Q3 ##1 phase_r == btov_pkg::BTOV_Q4 ##1 dmem_o.wr)
    else $error("read not followed by write");
  access_bank_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_instr && is_inv && !bank_flag |=> addr_r[btov_pkg::ADDR_W-1:8] ==
    (($past(file_a) < btov_pkg::ACCESS_SPLIT) ? btov_pkg::ACCESS_BANK_LO
                                              : btov_pkg::ACCESS_BANK_HI))
    else $error("access bank not used");
  sel_bank_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_instr && is_inv && bank_flag |=>
    addr_r[btov_pkg::ADDR_W-1:8] == $past(bank_select_reg_i))
    else $error("bank select not used");
  no_flags_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !flags_we_o) else $error("flags written");
  not_taken_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_instr && is_br && !ovf_flag_i |-> ##4 !pc_load_o [*4])
    else $error("branch taken without overflow");
  target_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_instr && is_br && ovf_flag_i |-> ##4 pc_load_o &&
    pc_o == $past(pc_r, 4) + PC_W'(2) + rel_off($past(offset, 4)))
    else $error("branch target wrong");
  refill_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    pc_load_o |-> flush_o && phase_r == btov_pkg::BTOV_Q1 ##1 !inv_r && !br_r)
    else $error("taken branch did not refill");

  cov_toggle_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) dmem_o.wr);
  cov_taken_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i) pc_load_o);
  cov_untaken_c: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
    new_instr && is_br && !ovf_flag_i);
endmodule
`default_nettype wire

//--- src/btov_pkg.sv
`default_nettype none
package btov_pkg;
  // Opcode fields of the 16-bit instruction word
  localparam logic [3:0] BIT_INVERT_NIB  = 4'h7;   // Top nibble of the bit toggle
  localparam logic [7:0] BRANCH_OVF_HI   = 8'he4;  // Upper byte of the overflow branch
  localparam int         OP_NIB_LSB      = 12;     // Top nibble position
  localparam int         BIT_IDX_LSB     = 9;      // Bit index field position
  localparam int         BANK_FLAG_POS   = 8;      // Bank flag position
  localparam int         OP_HI_LSB       = 8;      // Upper byte position
  localparam int         PC_W            = 21;     // Program counter width
  localparam int         ADDR_W          = 12;     // Data address width
  localparam logic [3:0] ACCESS_BANK_LO  = 4'h0;   // Bank for access addresses below split
  localparam logic [3:0] ACCESS_BANK_HI  = 4'hf;   // Bank for access addresses at or above split
  localparam logic [7:0] ACCESS_SPLIT    = 8'h80;  // First file address in upper access half

  // Quarter phases of one instruction cycle, Gray coded
  typedef enum logic [1:0] {
    BTOV_Q1 = 2'b00,
    BTOV_Q2 = 2'b01,
    BTOV_Q3 = 2'b11,
    BTOV_Q4 = 2'b10
  } btov_phase_t;

  // Data memory request carried as one bundle
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
  } btov_dmem_t;
endpackage
`default_nettype wire

//--- src/btov_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Pure opcode decoder for the two instructions
module btov_decode (
  // Instruction word
  input  wire logic [15:0] instr_i,
  // Decoded fields
  output logic             is_invert_o,
  output logic             is_branch_o,
  output logic [2:0]       bit_idx_o,
  output logic             bank_flag_o,
  output logic [7:0]       file_o,
  output logic [7:0]       offset_o
);
  // Nibble 0111 selects the bit toggle
  assign is_invert_o = instr_i[15:btov_pkg::OP_NIB_LSB] == btov_pkg::BIT_INVERT_NIB;
  // Upper byte 1110 0100 selects the overflow branch
  assign is_branch_o = instr_i[15:btov_pkg::OP_HI_LSB] == btov_pkg::BRANCH_OVF_HI;
  assign bit_idx_o   = instr_i[btov_pkg::OP_NIB_LSB-1:btov_pkg::BIT_IDX_LSB];
  assign bank_flag_o = instr_i[btov_pkg::BANK_FLAG_POS];
  assign file_o      = instr_i[7:0];
  assign offset_o    = instr_i[7:0];
endmodule
`default_nettype wire

//--- testbench/test_bit_toggle_and_overflow_branch.sv
`timescale 1ns/10ps
`default_nettype none
module test_bit_toggle_and_overflow_branch;
  // Stimulus, driven at the falling edge
  logic                  core_clk_i, rst_n_i, instr_vld_i, ovf_flag_i;
  logic [15:0]           instr_i;
  logic [3:0]            bank_select_reg_i;
  logic [7:0]            dmem_rdata_i;
  // Observed outputs
  btov_pkg::btov_dmem_t  dmem_o;
  btov_pkg::btov_phase_t phase_o;
  logic [20:0]           pc_o;
  logic                  pc_load_o, flush_o, flags_we_o;
  // Bookkeeping
  int                    failures = 0, check_count = 0, cyc = 0;
  logic [31:0]           seed = 32'h34a0, r;
  btov_core dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .instr_i(instr_i),
    .instr_vld_i(instr_vld_i), .ovf_flag_i(ovf_flag_i), .bank_select_reg_i(bank_select_reg_i),
    .dmem_o(dmem_o), .dmem_rdata_i(dmem_rdata_i), .pc_o(pc_o), .pc_load_o(pc_load_o),
    .phase_o(phase_o), .flush_o(flush_o), .flags_we_o(flags_we_o));

  // Free running clock, 4 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // Hang guard, far above the expected run length
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected data address: access bank split, or bank select
  function automatic logic [11:0] exp_addr(input logic a, input logic [3:0] bank_sel,
                                           input logic [7:0] f);
    if (a) return {bank_sel, f};
    return {(f < btov_pkg::ACCESS_SPLIT) ? btov_pkg::ACCESS_BANK_LO : btov_pkg::ACCESS_BANK_HI, f};
  endfunction

  // Expected target: branch address plus two plus doubled signed offset
  function automatic logic [20:0] exp_target(input logic [20:0] pc0, input logic [7:0] n);
    return pc0 + 21'h2 + {{12{n[7]}}, n, 1'b0};
  endfunction

  // One comparison, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Issue one word at a free Q1, follow it to the next
  task automatic issue(input logic [15:0] w, input logic ovf, input logic [3:0] bank_sel,
                       input logic [7:0] rd);
    logic [20:0] pc0;
    logic [11:0] ea;
    logic        tog, taken;
    logic [2:0]  seen = 3'h0;
    int          n = 0;
    tog   = w[15:12] == btov_pkg::BIT_INVERT_NIB;
    taken = (w[15:8] == btov_pkg::BRANCH_OVF_HI) & ovf;
    ea    = exp_addr(w[8], bank_sel, w[7:0]);
    while (!(phase_o === btov_pkg::BTOV_Q1 && flush_o === 1'b0)) @(negedge core_clk_i);
    pc0 = pc_o;
    {instr_i, instr_vld_i, ovf_flag_i, bank_select_reg_i} = {w, 1'b1, ovf, bank_sel};
    for (int i = 1; i <= 12 && n == 0; i++) begin
      @(negedge core_clk_i);
      chk(32'(flags_we_o), 32'h0);
      // Read data valid only while rd stands
      dmem_rdata_i = (dmem_o.rd === 1'b1) ? rd : ~rd;
      if (dmem_o.rd === 1'b1) begin
        seen[2] = 1'b1;
        chk(32'(phase_o), 32'(btov_pkg::BTOV_Q3));
        chk(32'(dmem_o.addr), 32'(ea));
      end
      if (dmem_o.wr === 1'b1) begin
        seen[1] = 1'b1;
        chk(32'(dmem_o.addr), 32'(ea));
        chk(32'(dmem_o.wdata), 32'(rd ^ (8'h01 << w[11:9])));
      end
      if (pc_load_o === 1'b1) begin
        seen[0] = 1'b1;
        chk(32'(pc_o), 32'(exp_target(pc0, w[7:0])));
      end
      // Toggle offered in refill must be ignored
      if (phase_o === btov_pkg::BTOV_Q1 && flush_o === 1'b0)
        n = i;
      else
        {instr_vld_i, instr_i} = {flush_o, 16'h7e10};
    end
    chk(32'(n), taken ? 32'h8 : 32'h4);
    chk(32'(pc_o), taken ? 32'(exp_target(pc0, w[7:0])) : 32'(pc0 + 21'h2));
    chk(32'(seen), {29'h0, tog, tog, taken});
    $display("word %h done at %0t", w, $time);
  endtask

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Main sequence: corners first, then random words
  initial begin
    {rst_n_i, instr_vld_i, ovf_flag_i, instr_i, bank_select_reg_i, dmem_rdata_i} = 31'h0;
    repeat (6) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    issue({4'h7, 3'h0, 1'b0, 8'h7f}, 1'b1, 4'h9, 8'h75);
    issue({4'h7, 3'h7, 1'b0, 8'h80}, 1'b0, 4'h9, 8'h00);
    issue({4'h7, 3'h4, 1'b1, 8'h12}, 1'b0, 4'h5, 8'h75);
    issue({8'he4, 8'h80}, 1'b1, 4'h0, 8'h00);
    issue({8'he4, 8'h7f}, 1'b1, 4'h0, 8'h00);
    issue({8'he4, 8'h05}, 1'b0, 4'h0, 8'h00);
    issue(16'he005, 1'b1, 4'h0, 8'h00);
    repeat (60) begin
      r = rnd();
      case (r[1:0])
        2'h0, 2'h1: issue({4'h7, r[10:8], r[11], r[19:12]}, r[20], r[24:21], r[31:24]);
        2'h2: issue({8'he4, r[19:12]}, r[20], r[24:21], r[31:24]);
        default: issue(r[31:16], r[20], r[24:21], r[15:8]);
      endcase
    end
    wrap_up();
  end
endmodule
`default_nettype wire
